/* hw/eds_regs.vh */
`ifndef EXTENDED_SPACE_REGS_VH
`define EXTENDED_SPACE_REGS_VH
// ==============================================================
// register offsets (byte addresses)
`define OFS_READ_PAGE 12'h000
`define OFS_WRITE_PAGE 12'h004
`define OFS_STATUS 12'h008
`define OFS_MASK 12'h00C
`define OFS_LAST_COST 12'h010
// ==============================================================
// reset values
`define RST_READ_PAGE 10'h001
`define RST_WRITE_PAGE 9'h001
// ==============================================================
// field layout
`define PAGE_BITS 9
`define PAGE_PSV_BIT 9
`define EA_WINDOW_BIT 15
`define EA_OFFSET_BITS 15
`define ST_TRAP 0
`define ST_RMW_REPEAT 1
`define ST_ROLLOVER 2
`define ST_WIDTH 3
// ==============================================================
// target select codes
`define SEL_LOWER 2'h0
`define SEL_EXTENDED 2'h1
`define SEL_PSV 2'h2
`define SEL_TRAP 2'h3
// ==============================================================
// access costs in instruction cycles, and how many repeat reads pay the head cost
`define COST_PLAIN 2'h1
`define COST_EXT_READ 2'h2
`define COST_REP_HEAD 2'h3
`define REP_HEAD_COUNT 2'h2
`endif

/* hw/extended_data_page_addressing.v */
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "eds_regs.vh"
module extended_data_page_addressing
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire acc_valid,
  input wire acc_write,
  input wire acc_rmw,
  input wire acc_repeat,
  input wire [15:0] acc_ea,
  output wire acc_done,
  output reg [23:0] mem_addr,
  output reg [1:0] mem_sel,
  output reg mem_we,
  output reg trap,
  output wire irq
);
  // ==============================================================
  // registers
  reg [9:0] read_page_select;
  reg [8:0] write_page_select;
  reg [`ST_WIDTH-1:0] status;
  reg [`ST_WIDTH-1:0] mask;
  reg [1:0] last_cost;
  reg [1:0] wait_cnt;
  reg [1:0] rep_index;
  reg [15:0] prev_ea;
  reg prev_ext;

  wire wr_acc = psel && penable && pwrite;
  wire rd_acc = psel && penable && !pwrite;
  // zero wait states: every transfer answers in its first access cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ==============================================================
  // access decode
  wire windowed = acc_ea[`EA_WINDOW_BIT];
  // rmw reads through the read page even though it also writes
  wire use_read_page = !acc_write || acc_rmw;
  wire program_space_view = windowed && use_read_page && read_page_select[`PAGE_PSV_BIT];
  wire [9:0] page_val = use_read_page ? read_page_select : {1'b0, write_page_select};
  wire page_zero = windowed && (page_val == 10'h000);
  wire ext_read = windowed && use_read_page && !page_zero;
  reg [1:0] cost;
  reg [23:0] next_addr;
  reg [1:0] next_sel;

  always @*
  begin
    next_addr = {8'h00, acc_ea};
    next_sel = `SEL_LOWER;
    if (!windowed)
    begin
      next_addr = {8'h00, acc_ea};
      next_sel = `SEL_LOWER;
    end
    else if (page_zero)
    begin
      next_addr = 24'h000000;
      next_sel = `SEL_TRAP;
    end
    else if (use_read_page)
    begin
      next_addr = {read_page_select[`PAGE_BITS-1:0], acc_ea[`EA_OFFSET_BITS-1:0]};
      next_sel = program_space_view ? `SEL_PSV : `SEL_EXTENDED;
    end
    else
    begin
      next_addr = {write_page_select, acc_ea[`EA_OFFSET_BITS-1:0]};
      next_sel = `SEL_EXTENDED;
    end
  end

  always @*
  begin
    cost = `COST_PLAIN;
    if (ext_read)
    begin
      if (acc_repeat)
        cost = (rep_index < `REP_HEAD_COUNT) ? `COST_REP_HEAD : `COST_PLAIN;
      else
        cost = `COST_EXT_READ;
    end
  end

  assign acc_done = acc_valid && (wait_cnt == cost - 2'h1);
  wire first_cycle = acc_valid && (wait_cnt == 2'h0);

  // ==============================================================
  // events
  wire ev_trap = first_cycle && page_zero;
  wire ev_rmw_rep = first_cycle && acc_rmw && acc_repeat && windowed;
  // pointer that wrapped inside the window; the page is left as it was
  wire ev_roll = first_cycle && windowed && prev_ext && (prev_ea == 16'hFFFF)
    && (acc_ea == 16'h8000);
  wire [`ST_WIDTH-1:0] ev;
  assign ev = {ev_roll, ev_rmw_rep, ev_trap};
  assign irq = |(status & mask);

  // ==============================================================
  // register file
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_page_select <= `RST_READ_PAGE;
      write_page_select <= `RST_WRITE_PAGE;
      mask <= 3'h0;
      status <= 3'h0;
    end
    else
    begin
      // page registers change only by software write, never on rollover
      if (wr_acc && paddr == `OFS_READ_PAGE)
        read_page_select <= pwdata[9:0];
      else if (wr_acc && paddr == `OFS_WRITE_PAGE)
        write_page_select <= pwdata[8:0];
      else if (wr_acc && paddr == `OFS_MASK)
        mask <= pwdata[`ST_WIDTH-1:0];
      // read clears; a new event in the same cycle survives
      if (rd_acc && paddr == `OFS_STATUS)
        status <= ev;
      else
        status <= status | ev;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == `OFS_READ_PAGE)
        prdata <= {22'h000000, read_page_select};
      else if (paddr == `OFS_WRITE_PAGE)
        prdata <= {23'h000000, write_page_select};
      else if (paddr == `OFS_STATUS)
        prdata <= {29'h00000000, status};
      else if (paddr == `OFS_MASK)
        prdata <= {29'h00000000, mask};
      else if (paddr == `OFS_LAST_COST)
        prdata <= {30'h00000000, last_cost};
      else
        prdata <= 32'h00000000;
    end
  end

  // ==============================================================
  // access sequencing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cnt <= 2'h0;
      rep_index <= 2'h0;
      last_cost <= 2'h0;
      mem_addr <= 24'h000000;
      mem_sel <= `SEL_LOWER;
      mem_we <= 1'b0;
      trap <= 1'b0;
      prev_ea <= 16'h0000;
      prev_ext <= 1'b0;
    end
    else
    begin
      trap <= ev_trap;
      if (first_cycle)
      begin
        mem_addr <= next_addr;
        mem_sel <= next_sel;
        mem_we <= acc_write && !page_zero;
        prev_ea <= acc_ea;
        prev_ext <= windowed;
      end
      if (acc_done)
      begin
        wait_cnt <= 2'h0;
        last_cost <= cost;
      end
      else if (acc_valid)
        wait_cnt <= wait_cnt + 2'h1;
      // count only the extended reads that pay the repeat head cost
      if (!acc_repeat)
        rep_index <= 2'h0;
      else if (acc_done && ext_read && rep_index < `REP_HEAD_COUNT)
        rep_index <= rep_index + 2'h1;
    end
  end
endmodule // extended_data_page_addressing

/* verification/extended_data_page_addressing_checker.sv */
`timescale 1ns/100ps
module extended_data_page_addressing_checker (
  input logic pclk,
  input logic presetn,
  input logic acc_valid,
  input logic acc_write,
  input logic acc_repeat,
  input logic [15:0] acc_ea,
  input logic acc_done,
  input logic [23:0] mem_addr,
  input logic [1:0] mem_sel,
  input logic mem_we,
  input logic trap
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // first cycle of each access
  logic mid;
  wire st = acc_valid && !mid;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mid <= 1'b0;
    else
      mid <= acc_valid && !acc_done;
  // ====
  // checks
  a_low_direct: assert property (st && !acc_ea[15] |=>
    mem_sel == 2'h0 && mem_addr == {8'h00, $past(acc_ea)}) else $error("lower access");
  a_offset_join: assert property (st && acc_ea[15] |=>
    mem_sel != 2'h1 || mem_addr[14:0] == $past(acc_ea[14:0])) else $error("offset");
  a_write_one: assert property (st && acc_write |-> acc_done) else $error("write cost");
  a_read_cost: assert property (st && !acc_write && acc_ea[15] && !acc_repeat |->
    if (acc_done) ##1 trap else ##1 acc_done) else $error("read cost");
  a_trap_sel: assert property (trap |-> mem_sel == 2'h3 && !mem_we) else $error("trap");
  a_trap_cause: assert property (trap |-> $past(st && acc_ea[15])) else $error("cause");
  a_write_view: assert property (st && acc_write |=> mem_sel != 2'h2) else $error("view");
  a_cost_bound: assert property ((acc_valid && !acc_done) [*2] |=> acc_done) else $error("slow");
  c_repeat: cover property (st && acc_repeat);
  c_trap: cover property (trap);
  c_view: cover property (mem_sel == 2'h2);
endmodule // extended_data_page_addressing_checker

/* verification/core_model.sv */
`timescale 1ns/100ps
module core_model (
  input logic pclk,
  input logic acc_done,
  output logic acc_valid = 1'b0,
  output logic acc_write = 1'b0,
  output logic acc_rmw = 1'b0,
  output logic acc_repeat = 1'b0,
  output logic [15:0] acc_ea = 16'h0000
);
  // entered just after a rising edge; done is sampled mid-cycle where it is settled
  task access(input logic w, r, rp, input logic [15:0] ea, output int n);
    logic d;
    n = 0;
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_rmw <= r && !rp;
    acc_repeat <= rp;
    acc_ea <= ea;
    do
    begin
      n++;
      @(negedge pclk) d = acc_done;
      @(posedge pclk);
    end
    while (!d);
  endtask
  // released pointer is inverted so no stale address looks valid
  task idle;
    acc_valid <= 1'b0;
    acc_repeat <= 1'b0;
    acc_ea <= ~acc_ea;
    @(posedge pclk);
  endtask
endmodule // core_model

/* verification/extended_data_page_addressing_tb.sv */
`timescale 1ns/100ps
`include "eds_regs.vh"
module extended_data_page_addressing_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic acc_valid, acc_write, acc_rmw, acc_repeat, acc_done, mem_we, trap, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] acc_ea;
  logic [23:0] mem_addr;
  logic [1:0] mem_sel;
  int mismatches = 0;
  int n_tests = 0;
  int n;
  extended_data_page_addressing i_extended_data_page_addressing (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_rmw(acc_rmw), .acc_repeat(acc_repeat), .acc_ea(acc_ea),
    .acc_done(acc_done), .mem_addr(mem_addr), .mem_sel(mem_sel), .mem_we(mem_we),
    .trap(trap), .irq(irq));
  core_model i_core_model (.pclk(pclk), .acc_done(acc_done), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_rmw(acc_rmw), .acc_repeat(acc_repeat), .acc_ea(acc_ea));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task end_sim;
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // address is not compared for view and trap targets
  task acc(input logic w, input logic [15:0] ea, input logic [31:0] c, input logic [1:0] s,
    input logic [23:0] a);
    i_core_model.access(w, 1'b0, 1'b0, ea, n);
    i_core_model.idle;
    chk(n, c);
    chk({6'h00, mem_sel, mem_addr & {24{!s[1]}}}, {6'h00, s, a});
    chk(mem_we, w && (s != `SEL_TRAP));
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OFS_READ_PAGE, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `OFS_READ_PAGE, 32'h2);
    apb(1'b1, `OFS_WRITE_PAGE, 32'h5);
    acc(1'b0, 16'h1234, 1, `SEL_LOWER, 24'h001234);
    acc(1'b0, 16'h8800, 2, `SEL_EXTENDED, 24'h010800);
    acc(1'b1, 16'h8800, 1, `SEL_EXTENDED, 24'h028800);
    acc(1'b0, 16'hFFFF, 2, `SEL_EXTENDED, 24'h017FFF);
    acc(1'b0, 16'h8000, 2, `SEL_EXTENDED, 24'h010000);
    for (int i = 0; i < 4; i++)
    begin
      i_core_model.access(1'b0, 1'b0, 1'b1, 16'h8000 + 16'(i), n);
      chk(n, (i < 2) ? 3 : 1);
    end
    i_core_model.idle;
    apb(1'b1, `OFS_READ_PAGE, 32'h200);
    acc(1'b0, 16'h8000, 2, `SEL_PSV, 24'h0);
    acc(1'b1, 16'h8002, 1, `SEL_EXTENDED, 24'h028002);
    apb(1'b1, `OFS_READ_PAGE, 32'h0);
    acc(1'b0, 16'h9000, 1, `SEL_TRAP, 24'h0);
    chk(irq, 1'b0);
    apb(1'b1, `OFS_MASK, 32'h1);
    chk(irq, 1'b1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[`ST_TRAP], 1'b1);
    chk(irq, 1'b0);
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0);
    chk({pready, pslverr}, 2'h2);
    end_sim;
  end
  initial
  begin
    #200000;
    mismatches++;
    end_sim;
  end
endmodule // extended_data_page_addressing_tb
bind extended_data_page_addressing extended_data_page_addressing_checker i_checker (.pclk(pclk),
  .presetn(presetn), .acc_valid(acc_valid), .acc_write(acc_write), .acc_repeat(acc_repeat),
  .acc_ea(acc_ea), .acc_done(acc_done), .mem_addr(mem_addr), .mem_sel(mem_sel),
  .mem_we(mem_we), .trap(trap));
